// >>> verif/sier_host_irq_model.sv
// host-side model of the two interrupt input lines
module sier_host_irq_model
(
  input  wire logic pin_a_o,
  input  wire logic pin_a_oe,
  input  wire logic pin_b_o,
  input  wire logic pin_b_oe,
  output logic      line_a,
  output logic      line_b
);
  timeunit 1ns;
  timeprecision 100ps;

  int service_count = 0;

  // ----------------------------------------------------------------------
  // board lines
  // ----------------------------------------------------------------------
  // board pull-up: a released pad reads high, never a stale level
  assign line_a = pin_a_oe ? pin_a_o : 1'h1;
  assign line_b = pin_b_oe ? pin_b_o : 1'h1;

  // each falling line would make the host read the source register
  always @(negedge line_a or negedge line_b)
  begin
    service_count++;
  end
endmodule

// >>> verif/sier_top_tb.sv
// self-checking bench for the interrupt enable and routing block
module sier_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] sel;
    logic [7:0] cfg;
    logic [7:0] flags;
    logic       a;
    logic       b;
  } sier_row_s;

  logic       ref_clk     = 1'h0;
  logic       sys_rst     = 1'h1;
  logic [7:0] reg_addr    = 8'h00;
  logic       reg_wr_en   = 1'h0;
  logic [7:0] reg_wr_data = 8'h00;
  logic       reg_rd_en   = 1'h0;
  logic [7:0] reg_rd_data;
  logic [7:0] event_flags = 8'h00;
  logic       a_o;
  logic       a_oe;
  logic       b_o;
  logic       b_oe;
  logic       line_a;
  logic       line_b;
  logic       host_seen;
  int         miscompares     = 0;
  int         samples_checked = 0;

  // enable, select, pin config, flags, expected line a and line b
  sier_row_s  rows [9] = '{
    '{8'h00, 8'hFF, 8'h00, 8'hFF, 1'h1, 1'h1},
    '{8'h80, 8'h80, 8'h00, 8'h80, 1'h0, 1'h1},
    '{8'h40, 8'h00, 8'h00, 8'h40, 1'h1, 1'h0},
    '{8'h30, 8'h20, 8'h22, 8'h30, 1'h1, 1'h1},
    '{8'h0C, 8'h04, 8'h00, 8'h08, 1'h1, 1'h0},
    '{8'h03, 8'h03, 8'h20, 8'h01, 1'h1, 1'h1},
    '{8'hFE, 8'hFF, 8'h00, 8'h01, 1'h1, 1'h1},
    '{8'hFF, 8'h0F, 8'h33, 8'hF0, 1'h0, 1'h1},
    '{8'hFF, 8'hF0, 8'h10, 8'hFF, 1'h0, 1'h0}};

  // ----------------------------------------------------------------------
  // design and host model
  // ----------------------------------------------------------------------
  sier_top i_sier_top (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .reg_addr     (reg_addr),
    .reg_wr_en    (reg_wr_en),
    .reg_wr_data  (reg_wr_data),
    .reg_rd_en    (reg_rd_en),
    .reg_rd_data  (reg_rd_data),
    .event_flags  (event_flags),
    .irq_pin_a_o  (a_o),
    .irq_pin_a_oe (a_oe),
    .irq_pin_b_o  (b_o),
    .irq_pin_b_oe (b_oe)
  );

  sier_host_irq_model i_sier_host_irq_model (
    .pin_a_o  (a_o),
    .pin_a_oe (a_oe),
    .pin_b_o  (b_o),
    .pin_b_oe (b_oe),
    .line_a   (line_a),
    .line_b   (line_b)
  );

  // the host model counts every falling line it would service
  assign host_seen = i_sier_host_irq_model.service_count > 0;

  // 40 MHz clock
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------------
  // tasks; all start and end 2 ns after a rising edge
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    reg_addr = addr;
    reg_wr_data = data;
    reg_wr_en = 1'h1;
    step(1);
    reg_wr_en = 1'h0;
    // idle edge so a following write never re-raises the strobe at once
    step(1);
  endtask

  // read data lands on the edge that takes the strobe; it is checked after the next edge
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp,
                    input string what);
    reg_addr = addr;
    reg_rd_en = 1'h1;
    @(posedge ref_clk);
    #2 reg_rd_en = 1'h0;
    @(posedge ref_clk);
    #2 check(reg_rd_data, exp, what);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard: a stuck run still reaches the verdict
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    $display("[ERR] %0t run timeout", $time);
    complete_run();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge ref_clk);
    #2 sys_rst = 1'h0;
    rd(sier_pkg::ADDR_PIN_CFG, 8'h00, "cfg reset");
    rd(sier_pkg::ADDR_IRQ_ENABLE, 8'h00, "enable reset");
    rd(sier_pkg::ADDR_PIN_SELECT, 8'h00, "select reset");
    check({7'h00, line_a}, 8'h01, "pin a idle");
    $display("reset test done");
    for (int i = 0; i < 9; i++)
    begin
      wr(sier_pkg::ADDR_IRQ_ENABLE, rows[i].en);
      wr(sier_pkg::ADDR_PIN_SELECT, rows[i].sel);
      wr(sier_pkg::ADDR_PIN_CFG, rows[i].cfg);
      event_flags = rows[i].flags;
      step(3);
      check({7'h00, line_a}, {7'h00, rows[i].a}, "line a");
      check({7'h00, line_b}, {7'h00, rows[i].b}, "line b");
      rd(sier_pkg::ADDR_IRQ_ENABLE, rows[i].en, "enable rd");
      rd(sier_pkg::ADDR_PIN_SELECT, rows[i].sel, "select rd");
      rd(sier_pkg::ADDR_PIN_CFG, rows[i].cfg & 8'h33, "cfg rd");
      $display("row %0d done", i);
    end
    // open drain must let go of an idle line
    event_flags = 8'h00;
    step(3);
    check({7'h00, a_oe}, 8'h00, "pin a released");
    check({7'h00, line_a}, 8'h01, "line a pulled up");
    $display("open drain test done");
    // unmapped write is dropped, mapped state untouched
    wr(8'h2B, 8'hA5);
    rd(8'h2B, sier_pkg::RD_UNMAPPED, "unmapped rd");
    rd(sier_pkg::ADDR_IRQ_ENABLE, 8'hFF, "enable kept");
    $display("unmapped test done");
    // reset in mid-run with a live source
    event_flags = 8'hFF;
    step(3);
    check({7'h00, line_a}, 8'h00, "line a live");
    sys_rst = 1'h1;
    step(2);
    check({7'h00, line_a}, 8'h01, "line a in reset");
    sys_rst = 1'h0;
    step(2);
    rd(sier_pkg::ADDR_IRQ_ENABLE, 8'h00, "enable cleared");
    check({7'h00, line_b}, 8'h01, "line b quiet");
    check({7'h00, host_seen}, 8'h01, "host serviced");
    $display("mid-run reset test done");
    complete_run();
  end
endmodule

// >>> verilog/sier_pin_driver.sv
// polarity and drive-mode stage for one interrupt pin
module sier_pin_driver
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic raw_irq,
  input  wire logic polarity,
  input  wire logic drive_mode,
  output logic      pin_o,
  output logic      pin_oe
);

  // ----------------------------------------------------------------------
  // pad state
  // ----------------------------------------------------------------------
  logic pin_o_reg;
  logic pin_o_next;
  logic pin_oe_reg;
  logic pin_oe_next;
  logic level;

  // polarity 0 means active low, so the raw request is inverted
  always_comb
  begin
    level = polarity ? raw_irq : ~raw_irq;
    if (drive_mode)
    begin
      // open drain only ever pulls low; the high level comes from outside
      pin_o_next  = 1'b0;
      pin_oe_next = ~level;
    end
    else
    begin
      pin_o_next  = level;
      pin_oe_next = 1'b1;
    end
  end

  // registered so the pad never sees decode glitches
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_o_reg  <= 1'b1;
      pin_oe_reg <= 1'b1;
    end
    else
    begin
      pin_o_reg  <= pin_o_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  assign pin_o  = pin_o_reg;
  assign pin_oe = pin_oe_reg;

endmodule

// >>> verilog/sier_pkg.sv
// constants shared by the interrupt enable and pin routing block
package sier_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int unsigned  REG_AW          = 8;
  localparam int unsigned  REG_DW          = 8;
  localparam int unsigned  NUM_SOURCES     = 8;
  localparam logic [7:0]   ADDR_PIN_CFG    = 8'h28;
  localparam logic [7:0]   ADDR_IRQ_ENABLE = 8'h29;
  localparam logic [7:0]   ADDR_PIN_SELECT = 8'h2A;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]   RST_PIN_CFG     = 8'h00;
  localparam logic [7:0]   RST_IRQ_ENABLE  = 8'h00;
  localparam logic [7:0]   RST_PIN_SELECT  = 8'h00;
  localparam logic [7:0]   RD_UNMAPPED     = 8'h00;

  // ----------------------------------------------------------------------
  // bit positions of the source enable and pin select fields
  // ----------------------------------------------------------------------
  localparam int unsigned  BIT_DATA_READY  = 7;
  localparam int unsigned  BIT_FIFO        = 6;
  localparam int unsigned  BIT_PRESS_WIN   = 5;
  localparam int unsigned  BIT_TEMP_WIN    = 4;
  localparam int unsigned  BIT_PRESS_THR   = 3;
  localparam int unsigned  BIT_TEMP_THR    = 2;
  localparam int unsigned  BIT_PRESS_CHG   = 1;
  localparam int unsigned  BIT_TEMP_CHG    = 0;

  // ----------------------------------------------------------------------
  // pin configuration field positions
  // ----------------------------------------------------------------------
  localparam int unsigned  BIT_A_POLARITY  = 5;
  localparam int unsigned  BIT_A_DRIVE     = 4;
  localparam int unsigned  BIT_B_POLARITY  = 1;
  localparam int unsigned  BIT_B_DRIVE     = 0;
  localparam logic [7:0]   PIN_CFG_MASK    = 8'h33;

  // select value that steers a source to pin a
  localparam logic         SEL_PIN_A       = 1'b1;
  localparam logic         SEL_PIN_B       = 1'b0;

endpackage

// >>> verilog/sier_top.sv
// interrupt enable, routing and pin control registers of the sensor
//
// Behaviour
// - a source reaches the pins only while its enable bit is set
// - enable register at 29h, bit 7 data ready, bit 6 fifo, reset 0
// - enable bit 5 pressure window, bit 4 temperature window, reset 0
// - enable bit 3 pressure threshold, bit 2 temperature threshold
// - enable bit 1 pressure change, bit 0 temperature change
// - select register at 2Ah, one bit per source, same layout, reset 0
// - select 1 steers a source to pin a, 0 to pin b
// - each pin is the OR of all enabled sources routed to it
// - pin a polarity bit at 28h, 0 active low, 1 active high
// - pin a drive bit, 0 push-pull, 1 open drain
module sier_top
#(
  parameter int unsigned NSRC = sier_pkg::NUM_SOURCES
)
(
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_wr_en,
  input  wire logic [7:0]       reg_wr_data,
  input  wire logic             reg_rd_en,
  output logic      [7:0]       reg_rd_data,
  input  wire logic [NSRC-1:0]  event_flags,
  output logic                  irq_pin_a_o,
  output logic                  irq_pin_a_oe,
  output logic                  irq_pin_b_o,
  output logic                  irq_pin_b_oe
);

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  logic [7:0]      pin_cfg_reg;
  logic [7:0]      pin_cfg_next;
  logic [7:0]      irq_enable_reg;
  logic [7:0]      irq_enable_next;
  logic [7:0]      pin_select_reg;
  logic [7:0]      pin_select_next;
  logic [7:0]      rd_data_reg;
  logic [7:0]      rd_data_next;

  logic            data_ready_irq_enable;
  logic            fifo_irq_enable;
  logic [7:0]      src_enable;
  logic            press_window_irq_enable;
  logic            temp_window_irq_enable;
  logic            press_threshold_irq_enable;
  logic            temp_threshold_irq_enable;
  logic            press_change_irq_enable;
  logic            temp_change_irq_enable;
  logic            irq_pin_a_polarity;
  logic            irq_pin_a_drive_mode;
  logic            irq_pin_b_polarity;
  logic            irq_pin_b_drive_mode;

  // named views of the enable fields
  assign data_ready_irq_enable      =
    irq_enable_reg[sier_pkg::BIT_DATA_READY];
  assign fifo_irq_enable            =
    irq_enable_reg[sier_pkg::BIT_FIFO];
  assign press_window_irq_enable    =
    irq_enable_reg[sier_pkg::BIT_PRESS_WIN];
  assign temp_window_irq_enable     =
    irq_enable_reg[sier_pkg::BIT_TEMP_WIN];
  assign press_threshold_irq_enable =
    irq_enable_reg[sier_pkg::BIT_PRESS_THR];
  assign temp_threshold_irq_enable  =
    irq_enable_reg[sier_pkg::BIT_TEMP_THR];
  assign press_change_irq_enable    =
    irq_enable_reg[sier_pkg::BIT_PRESS_CHG];
  assign temp_change_irq_enable     =
    irq_enable_reg[sier_pkg::BIT_TEMP_CHG];

  // gating vector rebuilt from the named fields; order follows bits 7..0
  assign src_enable = {data_ready_irq_enable, fifo_irq_enable,
                       press_window_irq_enable, temp_window_irq_enable,
                       press_threshold_irq_enable, temp_threshold_irq_enable,
                       press_change_irq_enable, temp_change_irq_enable};
  assign irq_pin_a_polarity   = pin_cfg_reg[sier_pkg::BIT_A_POLARITY];
  assign irq_pin_a_drive_mode = pin_cfg_reg[sier_pkg::BIT_A_DRIVE];
  assign irq_pin_b_polarity   = pin_cfg_reg[sier_pkg::BIT_B_POLARITY];
  assign irq_pin_b_drive_mode = pin_cfg_reg[sier_pkg::BIT_B_DRIVE];

  // write decode and read mux; reserved config bits stay zero
  always_comb
  begin
    pin_cfg_next    = pin_cfg_reg;
    irq_enable_next = irq_enable_reg;
    pin_select_next = pin_select_reg;
    rd_data_next    = rd_data_reg;
    if (reg_wr_en)
    begin
      case (reg_addr)
        sier_pkg::ADDR_PIN_CFG:
          pin_cfg_next = reg_wr_data & sier_pkg::PIN_CFG_MASK;
        sier_pkg::ADDR_IRQ_ENABLE:
          irq_enable_next = reg_wr_data;
        sier_pkg::ADDR_PIN_SELECT:
          pin_select_next = reg_wr_data;
        default:
          pin_cfg_next = pin_cfg_reg;
      endcase
    end
    if (reg_rd_en)
    begin
      case (reg_addr)
        sier_pkg::ADDR_PIN_CFG:    rd_data_next = pin_cfg_reg;
        sier_pkg::ADDR_IRQ_ENABLE: rd_data_next = irq_enable_reg;
        sier_pkg::ADDR_PIN_SELECT: rd_data_next = pin_select_reg;
        default:                   rd_data_next = sier_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // every source disabled and routed to pin b out of reset
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_cfg_reg    <= sier_pkg::RST_PIN_CFG;
      irq_enable_reg <= sier_pkg::RST_IRQ_ENABLE;
      pin_select_reg <= sier_pkg::RST_PIN_SELECT;
      rd_data_reg    <= sier_pkg::RD_UNMAPPED;
    end
    else
    begin
      pin_cfg_reg    <= pin_cfg_next;
      irq_enable_reg <= irq_enable_next;
      pin_select_reg <= pin_select_next;
      rd_data_reg    <= rd_data_next;
    end
  end

  assign reg_rd_data = rd_data_reg;

  // ----------------------------------------------------------------------
  // per-source gating and routing
  // ----------------------------------------------------------------------
  logic [NSRC-1:0] gated;
  logic [NSRC-1:0] to_pin_a;
  logic [NSRC-1:0] to_pin_b;
  logic            raw_a;
  logic            raw_b;

  // enables cover bits 7..0: data ready, fifo, windows, thresholds, change
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++)
    begin : g_src
      assign gated[gi]    = event_flags[gi] & src_enable[gi];
      assign to_pin_a[gi] = gated[gi] &
                            (pin_select_reg[gi] == sier_pkg::SEL_PIN_A);
      assign to_pin_b[gi] = gated[gi] &
                            (pin_select_reg[gi] == sier_pkg::SEL_PIN_B);
    end
  endgenerate

  // several sources may share a pin, so the host must read the source
  // register to tell them apart
  assign raw_a = |to_pin_a;
  assign raw_b = |to_pin_b;

  // ----------------------------------------------------------------------
  // pad stages
  // ----------------------------------------------------------------------
  sier_pin_driver u_pin_a
  (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .raw_irq    (raw_a),
    .polarity   (irq_pin_a_polarity),
    .drive_mode (irq_pin_a_drive_mode),
    .pin_o      (irq_pin_a_o),
    .pin_oe     (irq_pin_a_oe)
  );

  sier_pin_driver u_pin_b
  (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .raw_irq    (raw_b),
    .polarity   (irq_pin_b_polarity),
    .drive_mode (irq_pin_b_drive_mode),
    .pin_o      (irq_pin_b_o),
    .pin_oe     (irq_pin_b_oe)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // line level as the host sees it, with an external pull-up
  logic line_a;
  logic line_b;
  logic exp_a;
  logic exp_b;
  assign line_a = irq_pin_a_oe ? irq_pin_a_o : 1'b1;
  assign line_b = irq_pin_b_oe ? irq_pin_b_o : 1'b1;
  assign exp_a  = |(event_flags & irq_enable_reg & pin_select_reg);
  assign exp_b  = |(event_flags & irq_enable_reg & ~pin_select_reg);

  sequence s_wr(logic [7:0] a);
    reg_wr_en && (reg_addr == a);
  endsequence

  sequence s_line_a_active;
    line_a == $past(irq_pin_a_polarity);
  endsequence

  sequence s_line_b_active;
    line_b == $past(irq_pin_b_polarity);
  endsequence

  AST_EN_WRITE: assert property (
    s_wr(sier_pkg::ADDR_IRQ_ENABLE) |=> irq_enable_reg == $past(reg_wr_data))
    else $error("enable register did not take the write");

  AST_EN_HOLD: assert property (
    !reg_wr_en |=> $stable(irq_enable_reg) && $stable(pin_select_reg))
    else $error("control register changed without a write");

  AST_SEL_WRITE: assert property (
    s_wr(sier_pkg::ADDR_PIN_SELECT) |=> pin_select_reg == $past(reg_wr_data))
    else $error("select register did not take the write");

  AST_ROUTE_A: assert property (
    exp_a |=> s_line_a_active)
    else $error("enabled source for pin a did not assert it");

  AST_ROUTE_B: assert property (
    exp_b |=> s_line_b_active)
    else $error("enabled source for pin b did not assert it");

  AST_MASK_A: assert property (
    !exp_a |=> line_a != $past(irq_pin_a_polarity))
    else $error("pin a asserted with no enabled routed source");

  AST_MASK_B: assert property (
    !exp_b |=> line_b != $past(irq_pin_b_polarity))
    else $error("pin b asserted with no enabled routed source");

  AST_PUSH_PULL: assert property (
    !irq_pin_a_drive_mode |=> irq_pin_a_oe)
    else $error("push-pull pin a not driven");

  AST_OPEN_DRAIN: assert property (
    irq_pin_a_drive_mode |=> !(irq_pin_a_oe && irq_pin_a_o))
    else $error("open-drain pin a drove high");

  AST_POL_IDLE: assert property (
    (!exp_a && !irq_pin_a_polarity && !irq_pin_a_drive_mode)
      |=> irq_pin_a_o ##1 1'b1)
    else $error("idle active-low pin a not high");

  AST_READBACK: assert property (
    reg_rd_en && reg_addr == sier_pkg::ADDR_IRQ_ENABLE
      |=> reg_rd_data == $past(irq_enable_reg))
    else $error("enable register read back wrong");

endmodule
